/* File: dv/solc_far_model.sv */
// far side: converter samples, over-range pulses, lock
// fire and lock move after a rising edge
`timescale 1ns/10ps
`default_nettype none
module solc_far_model (
    input wire logic mclk,
    input wire logic lock,
    input wire logic [7:0] fire,
    output logic pll_locked,
    output logic [7:0] ovr_event,
    output logic [13:0] chan_a_in,
    output logic [13:0] chan_b_in
);
    always @(posedge mclk) begin
        {ovr_event, pll_locked} <= {fire, lock};
        {chan_a_in, chan_b_in} <= 28'($urandom);
    end
endmodule
`default_nettype wire

/* File: dv/solc_regs_checker.sv */
// assertions on the bank ports
// bound onto solc_regs
`timescale 1ns/10ps
`default_nettype none
module solc_checker import solc_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr,
    input wire logic rd,
    input wire logic pll_locked,
    input wire logic rate_band_low,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [7:0] ovr_event,
    input wire logic [13:0] chan_a_in,
    input wire logic [13:0] chan_b_in,
    input wire logic [13:0] chan_a_out,
    input wire logic [13:0] chan_b_out,
    input wire solc_link_t link_cfg
);
    wire logic wq = wr && addr == OFS_QUICK;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence rq(a); rd && addr == a; endsequence
    sequence set_rd; ovr_event[0] ##1 rq(OFS_OVR_STATUS); endsequence
    sequence clr_rd; wr && addr == OFS_OVR_CLEAR && wdata[1] && !ovr_event[1]
        ##1 !ovr_event[1] ##1 rq(OFS_OVR_STATUS); endsequence
    flag_set_a: assert property (set_rd |=> rdata[0]) else $error("set");
    flag_clear_a: assert property (clr_rd |=> !rdata[1]) else $error("clear");
    order_swap_a: assert property (rq(OFS_ORDER) |=> rdata[7:1] == 7'h0 &&
        chan_a_out == (rdata[0] ? $past(chan_b_in) : $past(chan_a_in))) else $error("swap");
    order_pair_a: assert property (rq(OFS_ORDER) |=>
        chan_b_out == (rdata[0] ? $past(chan_a_in) : $past(chan_b_in))) else $error("swap b");
    rate_band_a: assert property (rq(OFS_RATE_BAND) |=> rdata == {3'h0, rate_band_low, 4'h0}) else $error("band");
    pll_lock_a: assert property (rq(OFS_PLL_LOCK) |=> rdata == {$past(pll_locked, 2), 7'h0}) else $error("lock");
    lane_count_a: assert property (wq |=> link_cfg.lanes == 4'h1 << $past(wdata[7:6])) else $error("lanes");
    conv_count_a: assert property (wq |=> link_cfg.converters == 8'h01 << $past(wdata[5:3])) else $error("convs");
    octet_count_a: assert property (wq |=> link_cfg.octets == 8'h01 << $past(wdata[2:0])) else $error("octets");
endmodule
bind solc_regs solc_checker u_chk (
    .mclk(mclk),
    .nrst(nrst),
    .wr(wr),
    .rd(rd),
    .pll_locked(pll_locked),
    .rate_band_low(rate_band_low),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata),
    .ovr_event(ovr_event),
    .chan_a_in(chan_a_in),
    .chan_b_in(chan_b_in),
    .chan_a_out(chan_a_out),
    .chan_b_out(chan_b_out),
    .link_cfg(link_cfg)
);
`default_nettype wire

/* File: dv/test_serial_output_link_status_config.sv */
// bench of the bank: reads noted in a queue, checked by a monitor
// far model feeds the converter side
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((e) !== (g)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_serial_output_link_status_config import solc_pkg::*;
;
    logic mclk = 0, nrst = 0, wr = 0, rd = 0, lock = 0, pend = 0, pll_locked, rate_band_low, irq;
    logic [11:0] addr = 0;
    logic [7:0] wdata = 0, fire = 0, rdata, ovr_event, v, e;
    logic [13:0] chan_a_in, chan_b_in, chan_a_out, chan_b_out;
    solc_link_t link_cfg;
    logic [7:0] exp_q[$];
    int errors = 0, n_checks = 0, cyc = 0;
    always #5 mclk = ~mclk;
    solc_regs u_solc_regs (.*);
    solc_far_model u_solc_far_model (.*);
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        if (!w) exp_q.push_back(d);
        @(posedge mclk);
        {wr, rd} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (pend) begin
            e = exp_q.pop_front();
            `CHK("rdata", e, rdata)
        end
        pend <= rd;
        if (cyc == 500) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h31ca_4af4));
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        acc(0, OFS_QUICK, RST_QUICK);
        repeat (3) begin
            v = 8'($urandom);
            acc(1, OFS_QUICK, v);
            `CHK("link", {4'h1 << v[7:6], 8'h01 << v[5:3], 8'h01 << v[2:0]}, link_cfg)
        end
        $display("link test done");
        v = v | 8'h03;
        fire <= v;
        @(posedge mclk);
        fire <= 8'h00;
        @(posedge mclk);
        acc(0, OFS_OVR_STATUS, v);
        `CHK("irq", 1'b0, irq)
        acc(1, OFS_IRQ_MASK, 8'h02);
        acc(1, OFS_OVR_CLEAR, 8'h00);
        `CHK("irq", 1'b1, irq)
        acc(1, OFS_OVR_CLEAR, 8'h02);
        acc(0, OFS_OVR_STATUS, v ^ 8'h02);
        `CHK("irq", 1'b0, irq)
        $display("flag test done");
        lock <= 1'b1;
        acc(0, OFS_ORDER, RST_ORDER);
        acc(1, OFS_ORDER, 8'h01);
        acc(0, OFS_ORDER, 8'h01);
        acc(1, OFS_RATE_BAND, 8'h10);
        acc(0, OFS_RATE_BAND, 8'h10);
        acc(1, OFS_PLL_LOCK, 8'h00);
        acc(0, OFS_PLL_LOCK, 8'h80);
        acc(0, 12'h0123, RD_UNMAPPED);
        $display("ctrl test done");
        repeat (2) @(posedge mclk);
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: verilog/solc_pkg.sv */
// constants, field layouts and carrier types of the serial output link register bank
// assumes one 100 MHz clock and a plain strobe register port
package solc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] OFS_OVR_CLEAR = 12'h0562;
    localparam logic [11:0] OFS_OVR_STATUS = 12'h0563;
    localparam logic [11:0] OFS_ORDER = 12'h0564;
    localparam logic [11:0] OFS_RATE_BAND = 12'h056e;
    localparam logic [11:0] OFS_PLL_LOCK = 12'h056f;
    localparam logic [11:0] OFS_QUICK = 12'h0570;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h05f0;
    localparam int ORDER_SWAP_BIT = 0;
    localparam int RATE_BAND_BIT = 4;
    localparam int PLL_LOCK_BIT = 7;
    localparam int QK_LANE_LSB = 6;
    localparam int QK_CONV_LSB = 3;
    localparam int QK_OCT_LSB = 0;
    localparam logic [7:0] RST_OVR = 8'h00;
    localparam logic [7:0] RST_ORDER = 8'h00;
    localparam logic [7:0] RST_RATE_BAND = 8'h00;
    localparam logic [7:0] RST_QUICK = 8'h88;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } solc_bus_t;

    typedef struct packed {
        logic [3:0] lanes;
        logic [7:0] converters;
        logic [7:0] octets;
    } solc_link_t;
endpackage

/* File: verilog/solc_pow2.sv */
// two to the power of a small field, one-hot result
// assumes field value below result width
`timescale 1ns/10ps
`default_nettype none
module solc_pow2 #(
    parameter int IN_W = 3,
    parameter int OUT_W = 8
) (
    input wire logic [IN_W-1:0] exponent,
    output logic [OUT_W-1:0] power
);
    always_comb begin
        power = '0;
        power[exponent] = 1'b1;
    end
endmodule
`default_nettype wire

/* File: verilog/solc_regs.sv */
// register bank for over-range flags, channel order, lane rate band, lock and quick link setup
// assumes synchronous inputs, a one-cycle strobe master and read data taken the cycle after
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module solc_regs
    import solc_pkg::*;
#(
    parameter int NUM_VC = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [NUM_VC-1:0] ovr_event,
    input wire logic pll_locked,
    input wire logic [13:0] chan_a_in,
    input wire logic [13:0] chan_b_in,
    output logic [13:0] chan_a_out,
    output logic [13:0] chan_b_out,
    output logic rate_band_low,
    output solc_link_t link_cfg,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ovr;
        logic [7:0] mask;
        logic swap;
        logic band;
        logic lock;
        logic [7:0] quick;
        logic [7:0] rdata;
        logic [13:0] a_out;
        logic [13:0] b_out;
        solc_link_t link;
        logic irq;
    } solc_state_t;

    solc_state_t st;
    solc_state_t next_st;
    solc_bus_t bus;
    logic [3:0] lanes_w;
    logic [7:0] conv_w;
    logic [7:0] oct_w;
    logic [7:0] next_quick_w;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // decode counts from the value about to be registered
    solc_pow2 #(.IN_W(2), .OUT_W(4)) u_lanes (
        .exponent(next_quick_w[QK_LANE_LSB +: 2]),
        .power(lanes_w)
    );
    solc_pow2 #(.IN_W(3), .OUT_W(8)) u_conv (
        .exponent(next_quick_w[QK_CONV_LSB +: 3]),
        .power(conv_w)
    );
    solc_pow2 #(.IN_W(3), .OUT_W(8)) u_oct (
        .exponent(next_quick_w[QK_OCT_LSB +: 3]),
        .power(oct_w)
    );

    assign next_quick_w = (bus.wr && hit(bus.addr, OFS_QUICK)) ? bus.wdata : st.quick;

    always_comb begin
        logic [7:0] clr;
        clr = '0;
        next_st = st;
        next_st.lock = pll_locked;
        if (bus.wr && hit(bus.addr, OFS_OVR_CLEAR)) begin
            clr = bus.wdata;
        end
        // set wins over clear
        next_st.ovr = (st.ovr & ~clr) | 8'(ovr_event);
        if (bus.wr) begin
            if (hit(bus.addr, OFS_ORDER)) begin
                next_st.swap = bus.wdata[ORDER_SWAP_BIT];
            end
            if (hit(bus.addr, OFS_RATE_BAND)) begin
                next_st.band = bus.wdata[RATE_BAND_BIT];
            end
            if (hit(bus.addr, OFS_IRQ_MASK)) begin
                next_st.mask = bus.wdata;
            end
        end
        next_st.quick = next_quick_w;
        next_st.link = '{lanes: lanes_w, converters: conv_w, octets: oct_w};
        next_st.a_out = st.swap ? chan_b_in : chan_a_in;
        next_st.b_out = st.swap ? chan_a_in : chan_b_in;
        next_st.irq = |(next_st.ovr & next_st.mask);
        next_st.rdata = RD_UNMAPPED;
        if (bus.rd) begin
            case (1'b1)
                hit(bus.addr, OFS_OVR_STATUS): next_st.rdata = st.ovr;
                hit(bus.addr, OFS_ORDER): next_st.rdata = {7'h00, st.swap};
                hit(bus.addr, OFS_RATE_BAND): next_st.rdata = {3'h0, st.band, 4'h0};
                hit(bus.addr, OFS_PLL_LOCK): next_st.rdata = {st.lock, 7'h00};
                hit(bus.addr, OFS_QUICK): next_st.rdata = st.quick;
                hit(bus.addr, OFS_IRQ_MASK): next_st.rdata = st.mask;
                default: next_st.rdata = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '{ovr: RST_OVR, mask: RST_MASK, swap: RST_ORDER[0], band: RST_RATE_BAND[RATE_BAND_BIT],
                     lock: 1'b0, quick: RST_QUICK, rdata: 8'h00, a_out: 14'h0000, b_out: 14'h0000,
                     link: '{lanes: 4'h4, converters: 8'h02, octets: 8'h01}, irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign chan_a_out = st.a_out;
    assign chan_b_out = st.b_out;
    assign rate_band_low = st.band;
    assign link_cfg = st.link;
    assign irq = st.irq;
endmodule
`default_nettype wire
